//--- rtl/rttl_regs.sv
/*
  Time-tag counter, interrupt log pointer/count, current message info word
  pointer and serial-host memory pointer, with host read/write port.
  Assumes host strobes, sync commands and interrupt events are synchronous
  to clk; ext_tick is an asynchronous pin and is synchronised here.
*/
// Notes on behaviour
// - free-running 16-bit time-tag; host reads live count, writes ignored.
// - time-tag clears on master reset pin or soft reset command.
// - tick period selected by 3-bit field: 2..64 us or external clock.
// - valid synchronize without data clears the time-tag.
// - host time-tag clear bit clears the counter at any moment.
// - both load option bits one: sync data always loaded into counter.
// - non-broadcast sync-with-data load completes before status starts.
// - both option bits zero: no load, status still sent, host acts.
// - options high-low 01 load sync data only when its bit 0 is zero.
// - options high-low 10 load sync data only when its bit 0 is one.
// - interrupt log register resets to 0x0040 on master reset only.
// - bits 7:0 give even next entry address, 0x40 to 0x5E.
// - bits 15:8 count logged interrupts since last read, stop at 255.
// - host read of interrupt log clears count, pointer untouched.
// - sixteen latest interrupts kept in 32-word ring 0x40..0x5F.
// - each interrupt stores a type word and a source address word.
// - source word is descriptor control word address, or 0 for hardware.
// - after entry at 0x5E/0x5F pointer wraps to 0x40.
// - message info pointer read-only, cleared by master reset only.
// - message info pointer loaded 5 us after message-active rises.
// - serial variant: host memory pointer read/write, master reset clears.
// - parallel variant: pointer writes ignored, reads return zero.
`timescale 1ns/100ps
`include "rttl_params.svh"

module rttl_regs #(
  parameter bit SERIAL_HOST = 1'b1,
  parameter int CLK_MHZ = `RTTL_CLK_MHZ,
  parameter int MIW_DELAY_US = `RTTL_MIW_DELAY_US
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic soft_reset_command,
  input wire rttl_pkg::rttl_res_e tick_resolution_select,
  input wire logic ext_tick,
  input wire logic tick_counter_clear_bit,
  input wire logic sync_load_option_low,
  input wire logic sync_load_option_high,
  input wire rttl_pkg::rttl_sync_s sync_cmd,
  output logic sync_load_done,
  input wire rttl_pkg::rttl_host_req_s host_req,
  output logic [15:0] host_rdata,
  input wire rttl_pkg::rttl_int_event_s int_event,
  output logic int_event_ready,
  output rttl_pkg::rttl_ram_wr_s ram_wr,
  input wire logic message_active,
  input wire logic [15:0] message_info_addr,
  output logic [15:0] host_memory_pointer
);
  import rttl_pkg::*;

  localparam int US_CYCLES = CLK_MHZ;
  localparam int BASE_CYCLES = `RTTL_TICK_BASE_US * US_CYCLES;
  localparam int MIW_CYCLES = MIW_DELAY_US * US_CYCLES;

  function automatic logic sel_hit(input logic [3:0] a, input logic [3:0] ofs);
    sel_hit = (a == ofs);
  endfunction : sel_hit

  // ----------------------------------------
  // tick generation
  // ----------------------------------------
  logic [9:0] base_cnt_q;
  logic base_tick;
  logic [4:0] div_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic tick;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base_cnt_q <= 10'h000;
    end else if (base_cnt_q == 10'(BASE_CYCLES - 1)) begin
      base_cnt_q <= 10'h000;
    end else begin
      base_cnt_q <= base_cnt_q + 10'h001;
    end
  end
  assign base_tick = (base_cnt_q == 10'(BASE_CYCLES - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 5'h00;
    end else if (base_tick) begin
      div_q <= div_q + 5'h01;
    end
  end

  // first flop only feeds second; edge detect reads the synchronised pair
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_tick;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  always_comb begin
    case (tick_resolution_select)
      RTTL_RES_2US: tick = base_tick;
      RTTL_RES_4US: tick = base_tick && (div_q[0] == 1'b1);
      RTTL_RES_8US: tick = base_tick && (div_q[1:0] == 2'h3);
      RTTL_RES_16US: tick = base_tick && (div_q[2:0] == 3'h7);
      RTTL_RES_32US: tick = base_tick && (div_q[3:0] == 4'hf);
      RTTL_RES_64US: tick = base_tick && (div_q == 5'h1f);
      default: tick = ext_s2_q && !ext_s3_q;
    endcase
  end

  // ----------------------------------------
  // time-tag counter
  // ----------------------------------------
  logic [15:0] time_tag_q;
  logic sync_load;
  logic [1:0] opt;

  assign opt = {sync_load_option_high, sync_load_option_low};

  always_comb begin
    sync_load = 1'b0;
    if (sync_cmd.with_data) begin
      case (opt)
        2'h3: sync_load = 1'b1;
        2'h1: sync_load = !sync_cmd.data[0];
        2'h2: sync_load = sync_cmd.data[0];
        default: sync_load = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      time_tag_q <= 16'h0000;
    end else if (soft_reset_command) begin
      time_tag_q <= 16'h0000;
    end else if (tick_counter_clear_bit) begin
      time_tag_q <= 16'h0000;
    end else if (sync_cmd.no_data) begin
      time_tag_q <= 16'h0000;
    end else if (sync_load) begin
      time_tag_q <= sync_cmd.data;
    end else if (tick) begin
      time_tag_q <= time_tag_q + 16'h0001;
    end
  end

  // status transmit waits for this, so the load is always in first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_load_done <= 1'b0;
    end else begin
      sync_load_done <= sync_cmd.with_data && !sync_cmd.broadcast;
    end
  end

  // ----------------------------------------
  // interrupt log
  // ----------------------------------------
  logic [7:0] log_ptr_q;
  logic [7:0] int_cnt_q;
  rttl_log_e log_state_q;
  logic [15:0] src_q;
  logic log_read;
  logic entry_done;

  assign log_read = host_req.rd && sel_hit(host_req.addr, `RTTL_OFS_INT_LOG);
  assign int_event_ready = (log_state_q == RTTL_LOG_IDLE);
  assign entry_done = (log_state_q == RTTL_LOG_SOURCE);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      log_state_q <= RTTL_LOG_IDLE;
      src_q <= 16'h0000;
      ram_wr <= '0;
    end else begin
      ram_wr.we <= 1'b0;
      case (log_state_q)
        RTTL_LOG_IDLE: begin
          if (int_event.valid) begin
            log_state_q <= RTTL_LOG_TYPE;
            ram_wr <= '{we: 1'b1, addr: {8'h00, log_ptr_q}, data: int_event.type_word};
            src_q <= int_event.from_message ? int_event.source_addr : `RTTL_HW_SOURCE;
          end
        end
        RTTL_LOG_TYPE: begin
          log_state_q <= RTTL_LOG_SOURCE;
          ram_wr <= '{we: 1'b1, addr: {8'h00, log_ptr_q | 8'h01}, data: src_q};
        end
        RTTL_LOG_SOURCE: log_state_q <= RTTL_LOG_IDLE;
        default: log_state_q <= RTTL_LOG_IDLE;
      endcase
    end
  end

  // pointer and count untouched by soft reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      log_ptr_q <= 8'(`RTTL_INT_LOG_RESET);
    end else if (entry_done) begin
      log_ptr_q <= (log_ptr_q == `RTTL_LOG_LAST) ? `RTTL_LOG_FIRST : log_ptr_q + 8'h02;
    end
  end

  // an entry finishing in the read cycle counts after the clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_cnt_q <= 8'h00;
    end else if (log_read) begin
      int_cnt_q <= entry_done ? 8'h01 : 8'h00;
    end else if (entry_done && int_cnt_q != `RTTL_CNT_MAX) begin
      int_cnt_q <= int_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------
  // message info pointer
  // ----------------------------------------
  logic [15:0] msg_info_q;
  logic active_q;
  logic [10:0] miw_cnt_q;
  logic miw_wait_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_q <= 1'b0;
      miw_wait_q <= 1'b0;
      miw_cnt_q <= 11'h000;
    end else begin
      active_q <= message_active;
      if (message_active && !active_q) begin
        miw_wait_q <= 1'b1;
        miw_cnt_q <= 11'h000;
      end else if (miw_wait_q) begin
        miw_cnt_q <= miw_cnt_q + 11'h001;
        if (miw_cnt_q == 11'(MIW_CYCLES - 1)) begin
          miw_wait_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      msg_info_q <= 16'h0000;
    end else if (miw_wait_q && miw_cnt_q == 11'(MIW_CYCLES - 1)) begin
      msg_info_q <= message_info_addr;
    end
  end

  // ----------------------------------------
  // host memory pointer and read mux
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      host_memory_pointer <= 16'h0000;
    end else if (SERIAL_HOST && host_req.wr && sel_hit(host_req.addr, `RTTL_OFS_HOST_PTR)) begin
      host_memory_pointer <= host_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      host_rdata <= 16'h0000;
    end else if (host_req.rd) begin
      case (host_req.addr)
        `RTTL_OFS_TIME_TAG: host_rdata <= time_tag_q;
        `RTTL_OFS_INT_LOG: host_rdata <= {int_cnt_q, log_ptr_q};
        `RTTL_OFS_MSG_INFO: host_rdata <= msg_info_q;
        `RTTL_OFS_HOST_PTR: host_rdata <= SERIAL_HOST ? host_memory_pointer : 16'h0000;
        default: host_rdata <= 16'h0000;
      endcase
    end
  end

endmodule : rttl_regs

//--- rtl/rttl_params.svh
/*
  Register offsets, log ring bounds, reset values and timing constants for the
  time-tag / interrupt-log register group. Assumes inclusion by bare name.
*/
`ifndef RTTL_PARAMS_SVH
`define RTTL_PARAMS_SVH

// ----------------------------------------
// register word offsets
// ----------------------------------------
`define RTTL_OFS_TIME_TAG 4'h8
`define RTTL_OFS_INT_LOG 4'h9
`define RTTL_OFS_MSG_INFO 4'ha
`define RTTL_OFS_HOST_PTR 4'hf

// ----------------------------------------
// reset values and log layout
// ----------------------------------------
`define RTTL_INT_LOG_RESET 16'h0040
`define RTTL_LOG_FIRST 8'h40
`define RTTL_LOG_LAST 8'h5e
`define RTTL_CNT_MAX 8'hff
`define RTTL_HW_SOURCE 16'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define RTTL_CLK_MHZ 200
`define RTTL_TICK_BASE_US 2
`define RTTL_MIW_DELAY_US 5

`endif

//--- rtl/rttl_pkg.sv
/*
  Types for the time-tag / interrupt-log register group.
  Assumes rttl_params.svh supplies the numeric constants.
*/
package rttl_pkg;

  typedef enum logic [2:0] {
    RTTL_RES_2US,
    RTTL_RES_4US,
    RTTL_RES_8US,
    RTTL_RES_16US,
    RTTL_RES_32US,
    RTTL_RES_64US,
    RTTL_RES_EXT,
    RTTL_RES_EXT2
  } rttl_res_e;

  // host register access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [15:0] wdata;
  } rttl_host_req_s;

  // synchronize mode command from the protocol engine
  typedef struct packed {
    logic no_data;
    logic with_data;
    logic broadcast;
    logic [15:0] data;
  } rttl_sync_s;

  // interrupt log write request and shared ram write port
  typedef struct packed {
    logic valid;
    logic [15:0] type_word;
    logic from_message;
    logic [15:0] source_addr;
  } rttl_int_event_s;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] data;
  } rttl_ram_wr_s;

  typedef enum logic [1:0] {
    RTTL_LOG_IDLE,
    RTTL_LOG_TYPE,
    RTTL_LOG_SOURCE
  } rttl_log_e;

endpackage : rttl_pkg

//--- tb/rttl_regs_chk.sv
/*
  Port-level assertions for rttl_regs.
  Assumes binding into rttl_regs; all signals on clk.
*/
`timescale 1ns/100ps
module rttl_regs_chk #(
  parameter bit SERIAL_HOST = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick_counter_clear_bit,
  input wire rttl_pkg::rttl_sync_s sync_cmd,
  input wire logic sync_load_done,
  input wire rttl_pkg::rttl_host_req_s host_req,
  input wire logic [15:0] host_rdata,
  input wire rttl_pkg::rttl_int_event_s int_event,
  input wire logic int_event_ready,
  input wire rttl_pkg::rttl_ram_wr_s ram_wr,
  input wire logic [15:0] host_memory_pointer
);
  import rttl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic acc;
  assign acc = int_event.valid && int_event_ready;
  // ----------------------------------------
  // interrupt log writes and pointer reads
  // ----------------------------------------
  chk_log_type_word: assert property (acc |=> ram_wr.we && !ram_wr.addr[0]
    && ram_wr.data == $past(int_event.type_word)) else $error("type word write wrong");
  chk_log_source_word: assert property (acc |-> ##2 ram_wr.we && ram_wr.data ==
    ($past(int_event.from_message, 2) ? $past(int_event.source_addr, 2) : 16'h0000))
    else $error("source word write wrong");
  chk_log_ring_range: assert property (ram_wr.we |-> ram_wr.addr >= 16'h0040
    && ram_wr.addr <= 16'h005f) else $error("log write outside ring");
  chk_log_pair_addr: assert property (ram_wr.we && !ram_wr.addr[0] |=> ram_wr.we
    && ram_wr.addr == $past(ram_wr.addr) + 16'h0001) else $error("second word address wrong");
  chk_log_ptr_form: assert property (host_req.rd && host_req.addr == 4'h9 |=>
    host_rdata[7:5] == 3'b010 && !host_rdata[0]) else $error("log pointer out of form");
  // ----------------------------------------
  // time-tag and host pointer
  // ----------------------------------------
  chk_sync_status_go: assert property (sync_cmd.with_data && !sync_cmd.broadcast
    |=> sync_load_done) else $error("no load done before status");
  chk_clear_holds_zero: assert property (host_req.rd && host_req.addr == 4'h8
    && tick_counter_clear_bit && $past(tick_counter_clear_bit) |=> host_rdata == 16'h0000)
    else $error("time-tag not held clear");
  // parallel variant keeps zero whatever is written
  chk_mem_ptr_write: assert property (host_req.wr && host_req.addr == 4'hf |=>
    host_memory_pointer == (SERIAL_HOST ? $past(host_req.wdata) : 16'h0000))
    else $error("memory pointer write wrong");
  cover property (acc);
  cover property (sync_cmd.with_data && !sync_cmd.broadcast);
  cover property (ram_wr.we && ram_wr.addr == 16'h005f);
endmodule : rttl_regs_chk
bind rttl_regs rttl_regs_chk #(.SERIAL_HOST(SERIAL_HOST)) chk_i (.*);

//--- tb/rttl_far.sv
/*
  Interrupt source model: issues a run of events, holding each until taken.
  Assumes start is a one-cycle pulse on clk.
*/
`timescale 1ns/100ps
module rttl_far (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [9:0] n_events,
  input wire logic int_event_ready,
  output rttl_pkg::rttl_int_event_s int_event,
  output logic busy
);
  import rttl_pkg::*;
  logic [9:0] left_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left_q <= 10'h0;
      int_event <= '0;
    end else if (start) begin
      left_q <= n_events;
    end else if (int_event.valid && int_event_ready) begin
      // released fields invert so stale values never look valid
      int_event <= {1'b0, ~int_event[32:0]};
      left_q <= left_q - 10'h1;
    end else if (left_q != 10'h0 && !int_event.valid) begin
      int_event <= {1'b1, 6'h00, left_q, left_q[0], 6'h10, left_q};
    end
  end
  assign busy = left_q != 10'h0;
endmodule : rttl_far

//--- tb/tb_rttl_regs.sv
/*
  Directed bench for rttl_regs with the interrupt source model.
  Assumes one 200 MHz clock; message delay shortened to 1 us.
*/
`timescale 1ns/100ps
module tb_rttl_regs;
  import rttl_pkg::*;
  logic clk = 0, resetn = 0, soft_reset_command = 0, ext_tick = 0, tick_counter_clear_bit = 0;
  logic sync_load_option_low = 0, sync_load_option_high = 0, message_active = 0, far_start = 0;
  rttl_res_e tick_resolution_select = RTTL_RES_EXT;
  rttl_sync_s sync_cmd = '0;
  rttl_host_req_s host_req = '0;
  logic [15:0] message_info_addr = 16'h0, host_rdata, host_memory_pointer;
  rttl_int_event_s int_event;
  rttl_ram_wr_s ram_wr;
  logic int_event_ready, sync_load_done, far_busy;
  logic [9:0] far_n = 10'h0;
  int miscompares = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  rttl_regs #(.MIW_DELAY_US(1)) DUT (.*);
  rttl_far far_i (.clk(clk), .resetn(resetn), .start(far_start), .n_events(far_n),
    .int_event_ready(int_event_ready), .int_event(int_event), .busy(far_busy));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk) host_req <= {1'b1, 1'b0, a, 16'h0};
    @(posedge clk) host_req.rd <= 1'b0;
    #1 d = host_rdata;
  endtask : rd
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask : rchk
  task automatic wr(input logic [3:0] a, input logic [15:0] w);
    @(posedge clk) host_req <= {1'b0, 1'b1, a, w};
    @(posedge clk) host_req.wr <= 1'b0;
  endtask : wr
  task automatic sync(input logic [1:0] o, input logic nd, wd, bc, input logic [15:0] d);
    @(posedge clk) sync_cmd <= {nd, wd, bc, d};
    {sync_load_option_high, sync_load_option_low} <= o;
    @(posedge clk) sync_cmd <= '0;
  endtask : sync
  task automatic run(input int k);
    @(posedge clk) far_start <= 1'b1;
    far_n <= k[9:0];
    @(posedge clk) far_start <= 1'b0;
    #1;
    for (int j = 0; j < 4000 && far_busy; j++) @(posedge clk);
    chk("source idle", 16'h0000, {15'h0000, far_busy});
    repeat (6) @(posedge clk);
  endtask : run
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (70000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [15:0] d, t0, t1;
    logic [1:0] o;
    int p;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rchk(4'h8, 16'h0000);
    rchk(4'h9, 16'h0040);
    rchk(4'ha, 16'h0000);
    rchk(4'hf, 16'h0000);
    wr(4'hf, 16'h1234);
    wr(4'ha, 16'hbeef);
    wr(4'h9, 16'hbeef);
    rchk(4'hf, 16'h1234);
    chk("mem ptr", 16'h1234, host_memory_pointer);
    rchk(4'ha, 16'h0000);
    rchk(4'h9, 16'h0040);
    rchk(4'h3, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      d = i[0] ? 16'h1231 : 16'h1230;
      o = i[2:1];
      sync(o, 1'b1, 1'b0, 1'b0, 16'h0);
      sync(o, 1'b0, 1'b1, i[0], d);
      rchk(4'h8, (o == 2'b11 || (o == 2'b01 && !d[0]) || (o == 2'b10 && d[0])) ? d : 16'h0);
    end
    sync(2'b11, 1'b0, 1'b1, 1'b0, 16'h7777);
    wr(4'h8, 16'hbeef);
    rchk(4'h8, 16'h7777);
    @(posedge clk) tick_counter_clear_bit <= 1'b1;
    // held two edges so the read sees the bit high now and one cycle back
    @(posedge clk);
    rchk(4'h8, 16'h0000);
    tick_counter_clear_bit <= 1'b0;
    @(posedge clk) message_info_addr <= 16'h3a5c;
    message_active <= 1'b1;
    repeat (190) @(posedge clk);
    rchk(4'ha, 16'h0000);
    repeat (20) @(posedge clk);
    rchk(4'ha, 16'h3a5c);
    sync(2'b11, 1'b0, 1'b1, 1'b0, 16'h5555);
    @(posedge clk) soft_reset_command <= 1'b1;
    @(posedge clk) soft_reset_command <= 1'b0;
    rchk(4'h8, 16'h0000);
    rchk(4'ha, 16'h3a5c);
    rchk(4'hf, 16'h1234);
    rchk(4'h9, 16'h0040);
    tick_resolution_select <= RTTL_RES_EXT2;
    sync(2'b11, 1'b0, 1'b1, 1'b0, 16'hfffe);
    repeat (3) begin
      @(posedge clk) ext_tick <= 1'b1;
      repeat (3) @(posedge clk);
      ext_tick <= 1'b0;
      repeat (3) @(posedge clk);
    end
    rchk(4'h8, 16'h0001);
    // reads exactly one period apart see one tick whatever the phase
    for (int s = 0; s < 6; s++) begin
      p = 400 << s;
      @(posedge clk) tick_resolution_select <= rttl_res_e'(s[2:0]);
      repeat (p) @(posedge clk);
      rd(4'h8, t0);
      repeat (p - 2) @(posedge clk);
      rd(4'h8, t1);
      chk("tick step", t0 + 16'h0001, t1);
    end
    run(17);
    rchk(4'h9, 16'h1142);
    rchk(4'h9, 16'h0042);
    run(256);
    rchk(4'h9, 16'hff42);
    print_verdict();
  end
endmodule : tb_rttl_regs
